//--- blp_ctrl.sv
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
module blp_ctrl
	import blp_pkg::*;
#(
	parameter int NUM_BLOCKS = 32
) (
	// Clock and reset
	input  wire logic        I_CLOCK,
	input  wire logic        I_NRST,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// Serial link pins
	input  wire logic        I_SCK,
	input  wire logic        I_CS_N,
	input  wire logic        I_SI,
	output logic             O_SO,
	output logic             O_SO_OE,
	// Reset sources
	input  wire logic        I_RESET_PIN_N,
	input  wire logic        I_JEDEC_RESET,
	// Program and erase engine
	input  wire logic        I_BUSY,
	input  wire logic        I_PE_REQ,
	input  wire logic [23:0] I_PE_ADDR,
	output logic             O_PE_ACK,
	output logic             O_PE_REJECT,
	output logic             O_HALT,
	output logic             O_DEV_RESET,
	output logic             O_SRAM_DROP
);
	// ========================================
	// Sizes
	localparam int BBITS = $clog2(NUM_BLOCKS);
	localparam int NL    = 2 * SUB_LOCKS + NUM_BLOCKS - 2;

	// Refuse sizes that the index map cannot serve
	if (NUM_BLOCKS < 4 || NUM_BLOCKS > 32 || (1 << BBITS) != NUM_BLOCKS) begin : g_bad_size
		$error("NUM_BLOCKS must be a power of two from 4 to 32");
	end

	function automatic logic [5:0] lock_index(input logic [23:0] addr);
		int blk;
		int sub;
		blk = int'(addr[BLOCK_BIT_LO +: BBITS]);
		sub = int'(addr[SUB_BIT_LO +: 4]);
		if (blk == 0)
			return 6'(sub);
		else if (blk == NUM_BLOCKS - 1)
			return 6'(SUB_LOCKS + sub);
		else
			return 6'(2 * SUB_LOCKS + blk - 1);
	endfunction

	// ========================================
	// Synchronisers
	logic cs_s1, cs_s2, cs_q;
	logic sck_s1, sck_s2, sck_q;
	logic si_s1, si_s2;
	logic rpin_s1, rpin_s2;

	// Pins come from outside the clock domain
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			{cs_s1, cs_s2, cs_q} <= 3'h7;
			{sck_s1, sck_s2, sck_q} <= 3'h0;
			{si_s1, si_s2} <= 2'h0;
			{rpin_s1, rpin_s2} <= 2'h3;
		end else begin
			cs_s1 <= I_CS_N;
			cs_s2 <= cs_s1;
			cs_q <= cs_s2;
			sck_s1 <= I_SCK;
			sck_s2 <= sck_s1;
			sck_q <= sck_s2;
			si_s1 <= I_SI;
			si_s2 <= si_s1;
			rpin_s1 <= I_RESET_PIN_N;
			rpin_s2 <= rpin_s1;
		end
	end

	logic sck_rise, sck_fall, cs_rise;
	assign sck_rise = sck_s2 & ~sck_q & ~cs_s2;
	assign sck_fall = ~sck_s2 & sck_q & ~cs_s2;
	assign cs_rise  = cs_s2 & ~cs_q;

	// ========================================
	// Configuration and state
	logic            pss, hw_rst_en, mode_sel;
	logic            armed, sram_lost, rd_active;
	logic [NL-1:0]   lock;
	logic [5:0]      bit_cnt;
	logic [31:0]     cmd_shift;
	logic [7:0]      op, out_shift;
	blp_pwr_t        pwr;

	logic [31:0] next_shift;
	logic [5:0]  cur_idx, pe_idx;
	assign next_shift = {cmd_shift[30:0], si_s2};
	assign cur_idx    = lock_index(cmd_shift[23:0]);
	assign pe_idx     = lock_index(I_PE_ADDR);

	// ========================================
	// Command decode at chip select release
	logic cmd8, cmd32, active, rd_op, pin_rst, rst99, ab_deep, ab_ultra;
	logic pd_enter, to_ultra, halt, dev_rst, lose_sram;
	logic set_one, clr_one, set_all, clr_all;

	assign cmd8   = cs_rise && bit_cnt == OPC_BITS;
	assign cmd32  = cs_rise && bit_cnt == ADDR_BITS;
	assign active = pwr == PWR_ACTIVE;
	assign rd_op  = op == OP_RDLOCK_A || op == OP_RDLOCK_B;
	assign pin_rst = ~rpin_s2 & hw_rst_en;
	assign rst99  = cmd8 && op == OP_RST && armed && pwr != PWR_ULTRA;
	assign ab_deep  = cmd8 && op == OP_RESUME && pwr == PWR_DEEP;
	assign ab_ultra = cmd8 && op == OP_RESUME && pwr == PWR_ULTRA;
	assign pd_enter = cmd8 && active && (op == OP_PD || op == OP_UPD);
	assign to_ultra = op == OP_UPD || !mode_sel;
	assign halt     = cmd8 && active && op == OP_TERM && I_BUSY;
	assign dev_rst  = I_JEDEC_RESET | pin_rst | rst99 | ab_ultra;
	assign lose_sram = I_JEDEC_RESET | pin_rst | ab_ultra | (pd_enter & to_ultra);
	assign set_one  = cmd32 && active && op == OP_LOCK;
	assign clr_one  = cmd32 && active && op == OP_UNLOCK;
	assign set_all  = cmd8 && active && op == OP_GLOCK;
	assign clr_all  = cmd8 && active && op == OP_GUNLOCK;

	// ========================================
	// Serial frame capture
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			bit_cnt <= 6'h00;
			cmd_shift <= 32'h0000_0000;
			op <= 8'h00;
		end else if (cs_s2) begin
			bit_cnt <= 6'h00;
		end else if (sck_rise) begin
			cmd_shift <= next_shift;
			// Saturate so that long frames count as incomplete
			if (bit_cnt != 6'h3F)
				bit_cnt <= bit_cnt + 6'h01;
			if (bit_cnt == OPC_BITS - 6'h01)
				op <= next_shift[7:0];
		end
	end

	// Lock field readout; data changes on falling edges for mode 0
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			rd_active <= 1'b0;
			out_shift <= 8'h00;
			O_SO <= 1'b0;
			O_SO_OE <= 1'b0;
		end else begin
			O_SO_OE <= rd_active & ~cs_s2;
			if (cs_s2) begin
				rd_active <= 1'b0;
			end else if (sck_rise && bit_cnt == ADDR_BITS - 6'h01 && rd_op && active) begin
				rd_active <= 1'b1;
				out_shift <= {7'h00, lock[lock_index(next_shift[23:0])]};
			end else if (sck_fall && rd_active) begin
				O_SO <= out_shift[7];
				out_shift <= {out_shift[6:0], out_shift[7]};
			end
		end
	end

	// ========================================
	// Lock bits
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			lock <= '1;
		end else if (dev_rst) begin
			lock <= '1;
		end else if (set_all) begin
			lock <= '1;
		end else if (clr_all) begin
			lock <= '0;
		end else if (set_one) begin
			lock[cur_idx] <= 1'b1;
		end else if (clr_one) begin
			lock[cur_idx] <= 1'b0;
		end
	end

	// Program and erase permission check
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_PE_ACK <= 1'b0;
			O_PE_REJECT <= 1'b0;
		end else begin
			O_PE_ACK <= I_PE_REQ;
			O_PE_REJECT <= I_PE_REQ & pss & lock[pe_idx];
		end
	end

	// ========================================
	// deselect never wakes; nor does terminate
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			pwr <= PWR_ACTIVE;
		end else if (dev_rst || ab_deep) begin
			pwr <= PWR_ACTIVE;
		end else if (pd_enter) begin
			pwr <= to_ultra ? PWR_ULTRA : PWR_DEEP;
		end
	end

	// Reset-enable arming; any other frame of one or more bits disarms
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			armed <= 1'b0;
		end else if (dev_rst) begin
			armed <= 1'b0;
		end else if (cs_rise && bit_cnt != 6'h00) begin
			// only a directly preceding 66h arms
			armed <= cmd8 && op == OP_RST_EN && pwr != PWR_ULTRA;
		end
	end

	// Pulses toward the rest of the device
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_DEV_RESET <= 1'b0;
			O_HALT <= 1'b0;
			O_SRAM_DROP <= 1'b0;
		end else begin
			O_DEV_RESET <= dev_rst;
			O_HALT <= halt & ~dev_rst;
			O_SRAM_DROP <= lose_sram;
		end
	end

	// ========================================
	// APB slave: one wait state, then the answer
	logic        apb_fire, apb_hit;
	logic [31:0] rd_word;
	logic [63:0] lock_pad;
	assign apb_fire = PSEL & PENABLE & PREADY;
	assign lock_pad = {{(64 - NL){1'b0}}, lock};

	// Read mux and decode
	always_comb begin
		rd_word = 32'h0000_0000;
		apb_hit = 1'b1;
		case (PADDR)
			OFS_SR3: begin
				rd_word[SR3_PSS_BIT] = pss;
				rd_word[SR3_HWRST_BIT] = hw_rst_en;
			end
			OFS_MODE: rd_word[MSEL_BIT] = mode_sel;
			OFS_STATUS: begin
				rd_word[ST_DEEP_BIT] = pwr == PWR_DEEP;
				rd_word[ST_ULTRA_BIT] = pwr == PWR_ULTRA;
				rd_word[ST_BUSY_BIT] = I_BUSY;
				rd_word[ST_LOST_BIT] = sram_lost;
				rd_word[ST_ARMED_BIT] = armed;
			end
			OFS_LOCK_LO: rd_word = lock_pad[31:0];
			OFS_LOCK_HI: rd_word = lock_pad[63:32];
			default: apb_hit = 1'b0;
		endcase
	end

	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			PREADY <= 1'b0;
			PRDATA <= 32'h0000_0000;
			PSLVERR <= 1'b0;
		end else begin
			PREADY <= PSEL & PENABLE & ~PREADY;
			if (PSEL && PENABLE && !PREADY) begin
				PRDATA <= PWRITE ? 32'h0000_0000 : rd_word;
				PSLVERR <= ~apb_hit;
			end
		end
	end

	// Configuration writes
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST) begin
			pss <= PSS_RST;
			hw_rst_en <= HWRST_RST;
			mode_sel <= MSEL_RST;
		end else if (apb_fire && PWRITE) begin
			if (PADDR == OFS_SR3) begin
				pss <= PWDATA[SR3_PSS_BIT];
				hw_rst_en <= PWDATA[SR3_HWRST_BIT];
			end
			if (PADDR == OFS_MODE)
				mode_sel <= PWDATA[MSEL_BIT];
		end
	end

	// Sticky buffer-lost flag; a new loss beats a clear
	always_ff @(posedge I_CLOCK or negedge I_NRST) begin
		if (!I_NRST)
			sram_lost <= 1'b1;
		else if (lose_sram)
			sram_lost <= 1'b1;
		else if (apb_fire && PWRITE && PADDR == OFS_STATUS && PWDATA[ST_LOST_BIT])
			sram_lost <= 1'b0;
	end

	// ========================================
	// Checks
	a_reset_relocks: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		O_DEV_RESET |-> &lock)
		else $error("lock bits not all set after device reset");
	a_lock_one_sets: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		set_one && !dev_rst |=> lock[$past(cur_idx)])
		else $error("individual lock did not set its bit");
	a_unlock_one_clears: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		clr_one && !dev_rst |=> !lock[$past(cur_idx)])
		else $error("individual unlock did not clear its bit");
	a_global_unlock: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		clr_all && !dev_rst |=> lock == '0 ##1 lock == '0 || $changed(cmd_shift) || cs_rise)
		else $error("global unlock left bits set");
	a_reject_map: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		I_PE_REQ |=> O_PE_ACK && O_PE_REJECT == ($past(pss) && $past(lock[pe_idx])))
		else $error("program erase permission wrong");
	a_pd_mode: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		pd_enter && !dev_rst |=> pwr == ($past(to_ultra) ? PWR_ULTRA : PWR_DEEP))
		else $error("wrong sleep mode entered");
	a_sleep_holds: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		!active && !dev_rst && !ab_deep |=> pwr == $past(pwr))
		else $error("left sleep without wake command or reset");
	a_resume_deep: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		ab_deep && !dev_rst |=> active && !O_DEV_RESET && !O_SRAM_DROP)
		else $error("deep wake misbehaved");
	a_resume_ultra: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		ab_ultra |=> active && O_DEV_RESET && O_SRAM_DROP && sram_lost)
		else $error("ultra wake did not reset");
	a_pair_ignored: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		pwr == PWR_ULTRA && cmd8 && op == OP_RST && !I_JEDEC_RESET && !pin_rst
		|=> pwr == PWR_ULTRA && !O_DEV_RESET)
		else $error("reset pair acted in ultra sleep");
	a_term_halts: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		halt && !dev_rst |=> O_HALT && !O_DEV_RESET && active)
		else $error("terminate did not just halt");
	a_readout_bit: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
		sck_fall && rd_active && !cs_s2 |=> O_SO == $past(out_shift[7]))
		else $error("lock field bit out of order");
endmodule

//--- blp_ctrl_tb.sv
`timescale 1ns/100ps
module blp_ctrl_tb;
	import blp_pkg::*;
	// ========================================
	// Nets and bookkeeping
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, pse;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic        sck, cs_n, si, so, so_oe, rst_pin_n, jedec, busy;
	logic        pe_req, pe_ack, pe_rej, halt, dev_rst, sram_drop;
	logic [23:0] pe_addr;
	logic [7:0]  fld;
	logic [61:0] exp_lock;
	logic [39:0] rows [9];
	int          err_count, compares, n_rst, n_halt, n_drop, r0, h0, d0;

	blp_ctrl dut (
		.I_CLOCK(clk), .I_NRST(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.I_SCK(sck), .I_CS_N(cs_n), .I_SI(si), .O_SO(so), .O_SO_OE(so_oe),
		.I_RESET_PIN_N(rst_pin_n), .I_JEDEC_RESET(jedec), .I_BUSY(busy), .I_PE_REQ(pe_req),
		.I_PE_ADDR(pe_addr), .O_PE_ACK(pe_ack), .O_PE_REJECT(pe_rej), .O_HALT(halt),
		.O_DEV_RESET(dev_rst), .O_SRAM_DROP(sram_drop)
	);
	blp_host host (
		.i_clk(clk), .o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so), .i_so_oe(so_oe)
	);

	// 125 MHz clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Count event pulses; scenarios only ask whether any occurred
	always @(posedge clk) begin
		n_rst  += (dev_rst === 1'b1);
		n_halt += (halt === 1'b1);
		n_drop += (sram_drop === 1'b1);
	end

	// ========================================
	// Shared tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		// Wait states are the slave's choice; only a hang is cut off
		while (pready !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		chk(n < 20, 1, "apb answer");
		rdv = prdata;
		pse = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic cmd(input logic [7:0] op, input logic [23:0] a);
		int n;
		n = (op == OP_LOCK || op == OP_UNLOCK) ? 32 : 8;
		if (op == OP_RDLOCK_A || op == OP_RDLOCK_B)
			n = 40;
		host.frame({op, a}, n, fld);
	endtask

	function automatic int lidx(input logic [23:0] a);
		if (a[20:16] == 5'h00)
			return a[15:12];
		if (a[20:16] == 5'h1F)
			return 16 + a[15:12];
		return 31 + a[20:16];
	endfunction

	task automatic locks();
		apb(1'b0, OFS_LOCK_LO, 32'h0);
		chk(rdv, exp_lock[31:0], "lock low");
		apb(1'b0, OFS_LOCK_HI, 32'h0);
		chk(rdv, {2'b00, exp_lock[61:32]}, "lock high");
		chk(pse, 1'b0, "mapped read error");
	endtask

	task automatic pwr(input logic [1:0] e);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk({rdv[ST_ULTRA_BIT], rdv[ST_DEEP_BIT]}, e, "power state");
	endtask

	task automatic ev(input logic [2:0] e);
		repeat (10) @(posedge clk);
		chk({n_rst != r0, n_halt != h0, n_drop != d0}, e, "reset halt drop events");
		r0 = n_rst;
		h0 = n_halt;
		d0 = n_drop;
	endtask

	task automatic pe(input logic [23:0] a, input logic e);
		@(posedge clk);
		pe_req  <= 1'b1;
		pe_addr <= a;
		@(posedge clk);
		pe_req <= 1'b0;
		@(posedge clk);
		chk({pe_ack, pe_rej}, {1'b1, e}, "program erase check");
	endtask

	task automatic report_and_stop();
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ========================================
	// Main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{busy, pe_req, pe_addr, jedec} = '0;
		rst_pin_n = 1'b1;
		rst_n     = 1'b0;
		// Command, address, expected lock field of that address afterwards
		rows = '{40'h98_000000_00, 40'h36_1F3000_01, 40'h36_00A000_01, 40'h36_051234_01,
			40'h36_1E0000_01, 40'h39_1F3000_00, 40'h7E_1F3000_01, 40'h39_010000_00,
			40'h39_1FF000_00};
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		exp_lock = '1;
		locks();
		cmd(OP_RDLOCK_A, 24'h1F3000);
		chk(fld, 8'h01, "field after reset");
		foreach (rows[i]) begin
			cmd(rows[i][39:32], rows[i][31:8]);
			case (rows[i][39:32])
				OP_GUNLOCK: exp_lock = '0;
				OP_GLOCK:   exp_lock = '1;
				OP_LOCK:    exp_lock[lidx(rows[i][31:8])] = 1'b1;
				default:    exp_lock[lidx(rows[i][31:8])] = 1'b0;
			endcase
			cmd(i[0] ? OP_RDLOCK_B : OP_RDLOCK_A, rows[i][31:8]);
			chk(fld, rows[i][7:0], "lock field");
			locks();
		end
		ev(3'b000);
		// Locks gate program and erase only under scheme select
		apb(1'b1, OFS_SR3, 32'h04);
		pe(24'h010000, 1'b0);
		pe(24'h1F3000, 1'b1);
		apb(1'b1, OFS_SR3, 32'h00);
		pe(24'h1F3000, 1'b0);
		// Deep sleep ignores deselect, terminate and lock frames
		apb(1'b1, OFS_MODE, 32'h80);
		cmd(OP_PD, 24'h0);
		cmd(OP_TERM, 24'h0);
		cmd(OP_LOCK, 24'h010000);
		pwr(2'b01);
		cmd(OP_RESUME, 24'h0);
		pwr(2'b00);
		ev(3'b000);
		locks();
		// Reset pair wakes deep sleep with the buffer kept
		cmd(OP_PD, 24'h0);
		cmd(OP_RST_EN, 24'h0);
		cmd(OP_RST, 24'h0);
		pwr(2'b00);
		ev(3'b100);
		exp_lock = '1;
		locks();
		cmd(OP_RST_EN, 24'h0);
		cmd(OP_GUNLOCK, 24'h0);
		cmd(OP_RST, 24'h0);
		exp_lock = '0;
		ev(3'b000);
		locks();
		// Ultra sleep ignores the pair and wakes by internal reset
		apb(1'b1, OFS_MODE, 32'h00);
		cmd(OP_PD, 24'h0);
		cmd(OP_RST_EN, 24'h0);
		cmd(OP_RST, 24'h0);
		pwr(2'b10);
		ev(3'b001);
		cmd(OP_RESUME, 24'h0);
		pwr(2'b00);
		ev(3'b101);
		exp_lock = '1;
		locks();
		apb(1'b1, OFS_MODE, 32'h80);
		cmd(OP_UPD, 24'h0);
		pwr(2'b10);
		ev(3'b001);
		@(posedge clk) jedec <= 1'b1;
		@(posedge clk) jedec <= 1'b0;
		pwr(2'b00);
		ev(3'b101);
		// Buffer-lost flag clears on a write of one
		apb(1'b1, OFS_STATUS, 32'h08);
		apb(1'b0, OFS_STATUS, 32'h0);
		chk(rdv[ST_LOST_BIT], 1'b0, "buffer lost flag cleared");
		// Reset pin must be enabled before sleeping
		apb(1'b1, OFS_SR3, 32'h80);
		cmd(OP_PD, 24'h0);
		pwr(2'b01);
		@(posedge clk) rst_pin_n <= 1'b0;
		repeat (5) @(posedge clk);
		rst_pin_n <= 1'b1;
		ev(3'b101);
		pwr(2'b00);
		chk(rdv[ST_LOST_BIT], 1'b1, "buffer lost after pin reset");
		// While busy terminate only halts, the pair resets
		busy <= 1'b1;
		cmd(OP_TERM, 24'h0);
		ev(3'b010);
		cmd(OP_RST_EN, 24'h0);
		cmd(OP_RST, 24'h0);
		ev(3'b100);
		busy <= 1'b0;
		apb(1'b0, 12'h020, 32'h0);
		chk(pse, 1'b1, "unmapped error");
		chk(rdv, 32'h0, "unmapped data");
		// Reset in mid-run relocks everything
		cmd(OP_GUNLOCK, 24'h0);
		@(posedge clk) rst_n <= 1'b0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		locks();
		report_and_stop();
	end

	// Whole run is about 19k cycles
	initial begin
		repeat (100000) @(posedge clk);
		err_count++;
		$display("ERROR %0t watchdog expired", $time);
		report_and_stop();
	end
endmodule

//--- blp_host.sv
`timescale 1ns/100ps
// ========================================
// Host serial controller model, mode 0
module blp_host (
	// Clock
	input  wire logic i_clk,
	// Link pins
	output logic      o_sck,
	output logic      o_cs_n,
	output logic      o_si,
	input  wire logic i_so,
	input  wire logic i_so_oe
);
	// Link idles deselected with its clock parked low
	initial begin
		o_sck  = 1'b0;
		o_cs_n = 1'b1;
		o_si   = 1'b0;
	end

	task automatic frame(input logic [31:0] w, input int n, output logic [7:0] rd);
		rd = 8'h00;
		@(posedge i_clk) o_cs_n <= 1'b0;
		for (int i = 0; i < n; i++) begin
			@(posedge i_clk) o_si <= (i < 32) ? w[31 - i] : ~o_si;
			// Nine plus one cycles low, ten high: a 160 ns link clock
			repeat (9) @(posedge i_clk);
			// An undriven line reads unknown, so silence never passes for data
			rd = {rd[6:0], i_so_oe ? i_so : 1'bx};
			o_sck <= 1'b1;
			repeat (10) @(posedge i_clk);
			o_sck <= 1'b0;
		end
		@(posedge i_clk) o_cs_n <= 1'b1;
		// Released line flips so a stale level is never read as a bit
		o_si <= ~o_si;
		repeat (40) @(posedge i_clk);
	endtask
endmodule

//--- blp_pkg.sv
package blp_pkg;
	// ========================================
	// Command opcodes
	localparam logic [7:0] OP_LOCK     = 8'h36;
	localparam logic [7:0] OP_UNLOCK   = 8'h39;
	localparam logic [7:0] OP_GLOCK    = 8'h7E;
	localparam logic [7:0] OP_GUNLOCK  = 8'h98;
	localparam logic [7:0] OP_RDLOCK_A = 8'h3C;
	localparam logic [7:0] OP_RDLOCK_B = 8'h3D;
	localparam logic [7:0] OP_PD       = 8'hB9;
	localparam logic [7:0] OP_UPD      = 8'h79;
	localparam logic [7:0] OP_RESUME   = 8'hAB;
	localparam logic [7:0] OP_RST_EN   = 8'h66;
	localparam logic [7:0] OP_RST      = 8'h99;
	localparam logic [7:0] OP_TERM     = 8'hF0;
	// Frame lengths in bits
	localparam logic [5:0] OPC_BITS    = 6'h08;
	localparam logic [5:0] ADDR_BITS   = 6'h20;
	// ========================================
	// Register byte offsets
	localparam logic [11:0] OFS_SR3     = 12'h000;
	localparam logic [11:0] OFS_MODE    = 12'h004;
	localparam logic [11:0] OFS_STATUS  = 12'h008;
	localparam logic [11:0] OFS_LOCK_LO = 12'h00C;
	localparam logic [11:0] OFS_LOCK_HI = 12'h010;
	// Field positions
	localparam int SR3_PSS_BIT   = 2;
	localparam int SR3_HWRST_BIT = 7;
	localparam int MSEL_BIT      = 7;
	localparam int ST_DEEP_BIT   = 0;
	localparam int ST_ULTRA_BIT  = 1;
	localparam int ST_BUSY_BIT   = 2;
	localparam int ST_LOST_BIT   = 3;
	localparam int ST_ARMED_BIT  = 4;
	// Reset values
	localparam logic PSS_RST   = 1'b0;
	localparam logic HWRST_RST = 1'b0;
	localparam logic MSEL_RST  = 1'b0;
	// ========================================
	// Address layout of the lock granules
	localparam int SUB_LOCKS   = 16;
	localparam int SUB_BIT_LO  = 12;
	localparam int BLOCK_BIT_LO = 16;
	// Power states
	typedef enum logic [2:0] {
		PWR_ACTIVE = 3'b001,
		PWR_DEEP   = 3'b010,
		PWR_ULTRA  = 3'b100
	} blp_pwr_t;
endpackage
